// [logic/fbm_ctrl.sv]
// flash controller: memory map, write buffer, prefetch, nvm protection
//
// Function
// - sram at fixed base, aliased at zero after remap
// - rom always mapped at its fixed base
// - flash always mapped at its fixed base
// - gp bit 2 picks zero alias; wipe clears
// - gp bits change only by set/clear commands, wipe and reset
// - one-page write buffer filled by 32-bit words
// - flash in standby when not accessed
// - wait states, commands, completion status via registers
// - error status and interrupt enables
// - two 32-bit prefetch words for 16-bit fetches
// - one controller instance per bank
// - 256-byte pages, 64-page lock regions
// - each lock bit guards erase and program; full erase here ignores the lock bits
// - locked target aborts command, raises interrupt
// - set-lock protects, clear-lock unprotects region
// - wipe pin clears all lock bits
// - security bit refuses debug and fast port
// - security only set by command, cleared by wipe then full erase
// - gp bit 0 enables brownout detector
// - gp bit 1 enables brownout reset
// - eight calibration bits fixed, wipe ignores them
// - wipe pin debounced at least 200 ms
// - gp bit 2 set boots from flash
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "fbm_defs.svh"
module fbm_ctrl #(
  parameter int unsigned WIPE_CYC = `FBM_WIPE_CYC // debounce length
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // system bus address decode
  input  wire logic [31:0]          bus_addr,
  output fbm_pkg::fbm_sel_e         bus_sel,
  // instruction fetch from flash
  input  wire logic                 fetch_req,
  input  wire logic [17:0]          fetch_addr,
  output logic                      fetch_hit,
  output logic      [15:0]          fetch_data,
  // flash array side
  input  wire logic [31:0]          array_rdata,
  output logic      [15:0]          array_word_addr,
  output logic                      array_rd,
  output logic                      array_standby,
  output logic                      array_prog,
  output logic      [31:0]          array_wdata,
  // wipe pin, debug and programming gates
  input  wire logic                 wipe_pin,
  input  wire logic                 debug_emulation_port_req,
  input  wire logic                 fast_programming_port_req,
  output logic                      debug_emulation_port_ok,
  output logic                      fast_programming_port_ok,
  // system side outputs
  output logic                      bod_enable,
  output logic                      bod_reset_enable,
  output logic                      boot_from_flash,
  output logic      [7:0]           calib_bits,
  output logic                      irq
);
  import fbm_pkg::*;

  localparam int unsigned OPW = $clog2(`FBM_OP_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic                      remap_q;      // sram alias at zero
  logic [1:0]                wait_q;       // wait state count
  logic [`FBM_LOCK_BITS-1:0] lock_q;       // region lock bits
  logic [`FBM_GP_BITS-1:0]   gp_q;         // general purpose nvm bits
  logic                      sec_q;        // security bit
  logic                      ready_q;      // last command done
  logic                      lockerr_q;    // locked target seen
  logic                      cmderr_q;     // bad key
  logic [1:0]                ien_q;        // irq enables: ready, error
  logic [31:0]               wbuf [`FBM_PAGE_WORDS]; // page buffer
  logic [5:0]                wptr_q;       // buffer fill index
  fbm_op_e                   op_q;         // running command
  logic [9:0]                arg_q;        // page or bit argument
  logic [OPW-1:0]            opcnt_q;      // operation timer
  logic [31:0]               wipe_cnt_q;   // debounce counter
  logic                      wipe_q;       // filtered wipe
  logic                      wipe_done_q;  // wipe taken this assertion
  logic                      wipe_erase_q; // wipe awaiting full erase

  // region of a page: 64 pages per region
  function automatic logic [3:0] region_of(input logic [9:0] page);
    region_of = page[9:6];
  endfunction

  // command needs lock check
  function automatic logic is_modify(input fbm_op_e op);
    is_modify = (op == FBM_OP_WRITE_PAGE) || (op == FBM_OP_ERASE_PAGE);
  endfunction

  wire logic cmd_wr  = reg_wr && (reg_addr == `FBM_REG_CMD);
  wire logic key_ok  = reg_wdata[`FBM_CMD_KEY_HI:`FBM_CMD_KEY_LO]
                       == `FBM_CMD_KEY;
  wire fbm_op_e new_op = fbm_op_e'(reg_wdata[3:0]);
  wire logic [9:0] new_arg = reg_wdata[`FBM_CMD_ARG_HI:`FBM_CMD_ARG_LO];
  wire logic start = cmd_wr && key_ok && ready_q && (new_op != FBM_OP_NONE);
  wire logic locked = is_modify(new_op) && lock_q[region_of(new_arg)];
  wire logic done  = (op_q != FBM_OP_NONE) && (opcnt_q == '0);

  ////////////////////////////////////////////////////////////////////////
  // address decoder
  always_comb begin
    unique case (bus_addr & `FBM_AREA_MASK)
      `FBM_FLASH_BASE: bus_sel = FBM_SEL_FLASH;
      `FBM_SRAM_BASE:  bus_sel = FBM_SEL_SRAM;
      `FBM_ROM_BASE:   bus_sel = FBM_SEL_ROM;
      32'h0000_0000: begin
        if (remap_q) bus_sel = FBM_SEL_SRAM;
        else if (gp_q[2]) bus_sel = FBM_SEL_FLASH;
        else bus_sel = FBM_SEL_ROM;
      end
      default:         bus_sel = FBM_SEL_NONE;
    endcase
  end

  // remap is one way until reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) remap_q <= 1'b0;
    else if (reg_wr && reg_addr == `FBM_REG_REMAP && reg_wdata[0])
      remap_q <= 1'b1;
  end

  // wait states
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) wait_q <= `FBM_WAIT_RESET;
    else if (reg_wr && reg_addr == `FBM_REG_MODE) begin
      wait_q <= reg_wdata[1:0];
    end
  end

  // interrupt enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ien_q <= 2'h0;
    else if (reg_wr && reg_addr == `FBM_REG_MODE) ien_q <= reg_wdata[9:8];
  end

  ////////////////////////////////////////////////////////////////////////
  // wipe pin debounce; a short glitch restarts the count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wipe_cnt_q <= 32'h0;
      wipe_q     <= 1'b0;
    end else if (!wipe_pin) begin
      wipe_cnt_q <= 32'h0;
      wipe_q     <= 1'b0;
    end else if (wipe_cnt_q >= WIPE_CYC - 1) begin
      wipe_q     <= 1'b1;
    end else begin
      wipe_cnt_q <= wipe_cnt_q + 32'h1;
    end
  end

  // one wipe per assertion
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) wipe_done_q <= 1'b0;
    else wipe_done_q <= wipe_q;
  end
  wire logic wipe_evt = wipe_q && !wipe_done_q;

  ////////////////////////////////////////////////////////////////////////
  // command sequencer; one operation at a time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_q    <= FBM_OP_NONE;
      arg_q   <= 10'h0;
      opcnt_q <= '0;
    end else if (start && !locked) begin
      op_q    <= new_op;
      arg_q   <= new_arg;
      opcnt_q <= OPW'(`FBM_OP_CYC - 1);
    end else if (done) begin
      op_q    <= FBM_OP_NONE;
    end else if (op_q != FBM_OP_NONE) begin
      opcnt_q <= opcnt_q - OPW'(1);
    end
  end

  // ready low while busy; abort leaves it set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ready_q <= 1'b1;
    else if (start && !locked) ready_q <= 1'b0;
    else if (done) ready_q <= 1'b1;
  end

  // error flags clear on status read, set wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lockerr_q <= 1'b0;
      cmderr_q  <= 1'b0;
    end else begin
      if (start && locked) lockerr_q <= 1'b1;
      else if (reg_rd && reg_addr == `FBM_REG_STATUS) lockerr_q <= 1'b0;
      if (cmd_wr && !key_ok) cmderr_q <= 1'b1;
      else if (reg_rd && reg_addr == `FBM_REG_STATUS) cmderr_q <= 1'b0;
    end
  end

  // lock bits: commands, or wipe clears all
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lock_q <= '0;
    else if (wipe_evt) lock_q <= '0;
    else if (done && op_q == FBM_OP_SET_LOCK)
      lock_q[region_of(arg_q)] <= 1'b1;
    else if (done && op_q == FBM_OP_CLR_LOCK)
      lock_q[region_of(arg_q)] <= 1'b0;
  end

  // gp bits: only commands change them, wipe and reset clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) gp_q <= '0;
    else if (wipe_evt) gp_q <= '0;
    else if (done && op_q == FBM_OP_SET_GP && arg_q < `FBM_GP_BITS)
      gp_q[arg_q[1:0]] <= 1'b1;
    else if (done && op_q == FBM_OP_CLR_GP && arg_q < `FBM_GP_BITS)
      gp_q[arg_q[1:0]] <= 1'b0;
  end

  // security: set by command; cleared only by reset or by wipe then full erase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_q        <= 1'b0;
      wipe_erase_q <= 1'b0;
    end else if (wipe_evt) begin
      wipe_erase_q <= 1'b1;
    end else if (done && op_q == FBM_OP_ERASE_ALL && wipe_erase_q) begin
      sec_q        <= 1'b0;
      wipe_erase_q <= 1'b0;
    end else if (done && op_q == FBM_OP_SET_SEC) begin
      sec_q        <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write buffer, filled one word at a time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) wptr_q <= 6'h0;
    else if (reg_wr && reg_addr == `FBM_REG_WADDR) wptr_q <= reg_wdata[5:0];
    else if (reg_wr && reg_addr == `FBM_REG_WBUF)
      wptr_q <= wptr_q + 6'h1;
  end
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == `FBM_REG_WBUF) wbuf[wptr_q] <= reg_wdata;
  end

  // programming streams buffer; word index follows timer
  wire logic [5:0] prog_idx = opcnt_q[5:0];

  ////////////////////////////////////////////////////////////////////////
  // prefetch: two words, refilled after wait states
  logic [31:0] pf_data_q [2];  // prefetched words
  logic [15:0] pf_addr_q [2];  // their word addresses
  logic [1:0]  pf_vld_q;       // entry valid
  logic [1:0]  pf_wait_q;      // wait-state counter
  logic        pf_busy_q;      // array read in flight
  logic [15:0] pf_want_q;      // word being read
  wire logic [15:0] f_word = fetch_addr[17:2];
  logic hit0, hit1;
  assign hit0 = pf_vld_q[0] && pf_addr_q[0] == f_word;
  assign hit1 = pf_vld_q[1] && pf_addr_q[1] == f_word;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pf_vld_q  <= 2'h0;
      pf_wait_q <= 2'h0;
      pf_busy_q <= 1'b0;
      pf_want_q <= 16'h0;
      pf_addr_q <= '{16'h0, 16'h0};
      pf_data_q <= '{32'h0, 32'h0};
    end else if (op_q != FBM_OP_NONE) begin
      pf_vld_q  <= 2'h0;   // array contents may change
      pf_busy_q <= 1'b0;
    end else if (pf_busy_q) begin
      if (pf_wait_q == 2'h0) begin
        pf_busy_q    <= 1'b0;
        pf_data_q[1] <= pf_data_q[0];
        pf_addr_q[1] <= pf_addr_q[0];
        pf_data_q[0] <= array_rdata;
        pf_addr_q[0] <= pf_want_q;
        pf_vld_q     <= {pf_vld_q[0], 1'b1};
      end else begin
        pf_wait_q <= pf_wait_q - 2'h1;
      end
    end else if (fetch_req && !hit0 && !hit1) begin
      pf_busy_q <= 1'b1;
      pf_want_q <= f_word;
      pf_wait_q <= wait_q;
    end else if (fetch_req && hit0) begin
      pf_busy_q <= 1'b1;                  // anticipate next word
      pf_want_q <= f_word + 16'h1;
      pf_wait_q <= wait_q;
    end
  end

  // fetch answer from prefetch buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_hit  <= 1'b0;
      fetch_data <= 16'h0;
    end else begin
      fetch_hit  <= fetch_req && (hit0 || hit1);
      if (hit0)
        fetch_data <= fetch_addr[1] ? pf_data_q[0][31:16] : pf_data_q[0][15:0];
      else if (hit1)
        fetch_data <= fetch_addr[1] ? pf_data_q[1][31:16] : pf_data_q[1][15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array drive; standby whenever idle
  always_comb begin
    array_rd        = pf_busy_q;
    array_prog      = (op_q == FBM_OP_WRITE_PAGE);
    array_standby   = !array_rd && (op_q == FBM_OP_NONE);
    array_word_addr = array_prog ? {arg_q, prog_idx} : pf_want_q;
    array_wdata     = array_prog ? wbuf[prog_idx] : 32'h0;
  end

  // gates and nvm outputs
  always_comb begin
    debug_emulation_port_ok  = debug_emulation_port_req && !sec_q;
    fast_programming_port_ok = fast_programming_port_req && !sec_q;
    bod_enable       = gp_q[0];
    bod_reset_enable = gp_q[1];
    boot_from_flash  = gp_q[2];
    calib_bits       = `FBM_CAL_RESET;
    irq              = (ien_q[0] && ready_q) ||
                       (ien_q[1] && (lockerr_q || cmderr_q));
  end

  ////////////////////////////////////////////////////////////////////////
  // register read, one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) reg_rdata <= 32'h0;
    else if (reg_rd) begin
      unique case (reg_addr)
        `FBM_REG_MODE:   reg_rdata <= {22'h0, ien_q, 6'h0, wait_q};
        `FBM_REG_STATUS: reg_rdata <= {27'h0, sec_q, 1'b0, cmderr_q,
                                       lockerr_q, ready_q};
        `FBM_REG_LOCKS:  reg_rdata <= {16'h0, lock_q};
        `FBM_REG_NVM:    reg_rdata <= {21'h0, gp_q, `FBM_CAL_RESET};
        `FBM_REG_REMAP:  reg_rdata <= {31'h0, remap_q};
        default:         reg_rdata <= 32'h0;
      endcase
    end else reg_rdata <= 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_lock_abort: assert property (@(posedge clk) disable iff (!reset_n)
    start && locked |=> lockerr_q && op_q == FBM_OP_NONE)
    else $error("locked command not aborted");
  a_busy_ready: assert property (@(posedge clk) disable iff (!reset_n)
    start && !locked |=> !ready_q [*3])
    else $error("ready high while busy");
  a_wipe_locks: assert property (@(posedge clk) disable iff (!reset_n)
    wipe_evt |=> lock_q == '0 && gp_q == '0)
    else $error("wipe left locks or gp set");
  a_sec_gate: assert property (@(posedge clk) disable iff (!reset_n)
    sec_q |-> !debug_emulation_port_ok && !fast_programming_port_ok)
    else $error("secured flash reachable");
  a_rom_fixed: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_addr & `FBM_AREA_MASK) == `FBM_ROM_BASE |-> bus_sel == FBM_SEL_ROM)
    else $error("rom not at base");
  a_zero_alias: assert property (@(posedge clk) disable iff (!reset_n)
    bus_addr[31:20] == 12'h0 && !remap_q |->
      bus_sel == (gp_q[2] ? FBM_SEL_FLASH : FBM_SEL_ROM))
    else $error("wrong zero alias");
  a_standby_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pf_busy_q && op_q == FBM_OP_NONE |-> array_standby)
    else $error("array not in standby");
  a_sec_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    sec_q && !wipe_erase_q |=> sec_q)
    else $error("security cleared without wipe");
  c_lock_abort: cover property (@(posedge clk) start && locked);
  c_prog_done: cover property (@(posedge clk)
    done && op_q == FBM_OP_WRITE_PAGE);
  c_fetch_hit: cover property (@(posedge clk) fetch_hit);
endmodule

// [logic/fbm_defs.svh]
// constants for the flash map and nvm protection block
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH
// address map
`define FBM_FLASH_BASE   32'h0010_0000
`define FBM_SRAM_BASE    32'h0020_0000
`define FBM_ROM_BASE     32'h0030_0000
`define FBM_AREA_MASK    32'hfff0_0000
// register offsets
`define FBM_REG_MODE     8'h00
`define FBM_REG_CMD      8'h04
`define FBM_REG_STATUS   8'h08
`define FBM_REG_LOCKS    8'h0c
`define FBM_REG_NVM      8'h10
`define FBM_REG_WBUF     8'h14
`define FBM_REG_WADDR    8'h18
`define FBM_REG_REMAP    8'h1c
// command register fields
`define FBM_CMD_KEY      8'h5a
`define FBM_CMD_KEY_HI   31
`define FBM_CMD_KEY_LO   24
`define FBM_CMD_ARG_HI   17
`define FBM_CMD_ARG_LO   8
// geometry
`define FBM_PAGE_WORDS   64
`define FBM_LOCK_BITS    16
`define FBM_GP_BITS      3
`define FBM_CAL_BITS     8
`define FBM_CAL_RESET    8'h00
`define FBM_WAIT_RESET   2'h1
// status bit positions
`define FBM_ST_READY     0
`define FBM_ST_LOCKERR   1
`define FBM_ST_CMDERR    2
`define FBM_ST_SECURE    4
// timing
`define FBM_CLK_HZ       100000000
`define FBM_OP_NS        1000
`define FBM_OP_CYC       ((`FBM_OP_NS * 100) / 1000)
`define FBM_WIPE_MS      200
`define FBM_WIPE_CYC     ((`FBM_WIPE_MS * (`FBM_CLK_HZ / 1000)))
`endif

// [logic/fbm_pkg.sv]
// types for the flash map and nvm protection block
package fbm_pkg;
  typedef enum logic [3:0] {
    FBM_OP_NONE, FBM_OP_WRITE_PAGE, FBM_OP_ERASE_PAGE, FBM_OP_ERASE_ALL,
    FBM_OP_SET_LOCK, FBM_OP_CLR_LOCK, FBM_OP_SET_GP, FBM_OP_CLR_GP,
    FBM_OP_SET_SEC
  } fbm_op_e;
  typedef enum logic [1:0] {FBM_SEL_NONE, FBM_SEL_FLASH, FBM_SEL_SRAM,
                            FBM_SEL_ROM} fbm_sel_e;
endpackage

// [test/fbm_array_model.sv]
// behavioural flash array that answers the controller's word reads
`timescale 1ns/10ps
module fbm_array_model (
  // clock
  input  wire logic        clk,
  // array side of the controller
  input  wire logic        array_rd,
  input  wire logic [15:0] array_word_addr,
  input  wire logic        array_prog,
  input  wire logic [31:0] array_wdata,
  output logic      [31:0] array_rdata,
  // capture of the programmed stream
  output logic      [31:0] prog_word
);
  logic [31:0] noise_q; // changes every cycle outside reads

  // free running pattern so a stale sample never looks right
  always @(posedge clk) begin
    noise_q <= noise_q + 32'h9e37_79b9;
  end

  // keep what was programmed at word one of the page
  always @(posedge clk) begin
    if (array_prog && array_word_addr[5:0] == 6'h01) begin
      prog_word <= array_wdata;
    end
  end

  initial begin
    noise_q = 32'h1234_5678;
  end

  // word content is the address and its inverse, only while reading
  assign array_rdata = array_rd ? {~array_word_addr, array_word_addr}
                                : noise_q;
endmodule

// [test/flash_boot_map_and_nvm_protection_bench.sv]
// self-checking bench for the flash map and nvm protection controller
`timescale 1ns/10ps
`include "fbm_defs.svh"
module flash_boot_map_and_nvm_protection_bench;
  import fbm_pkg::*;
  logic clk, reset_n, reg_wr, reg_rd, fetch_req, fetch_hit, array_rd;
  logic array_standby, array_prog, wipe_pin, dbg_req, fast_req;
  logic dbg_ok, fast_ok, bod_enable, bod_reset_enable, boot_from_flash;
  logic irq;
  logic [7:0]  reg_addr, calib_bits;
  logic [31:0] reg_wdata, reg_rdata, bus_addr, array_rdata, array_wdata;
  logic [31:0] prog_word;
  logic [17:0] fetch_addr;
  logic [15:0] fetch_data, array_word_addr;
  fbm_sel_e    bus_sel;
  int          failures, n_checks, cyc;

  fbm_ctrl #(.WIPE_CYC(20)) dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_addr(bus_addr), .bus_sel(bus_sel),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_hit(fetch_hit), .fetch_data(fetch_data),
    .array_rdata(array_rdata), .array_word_addr(array_word_addr),
    .array_rd(array_rd), .array_standby(array_standby),
    .array_prog(array_prog), .array_wdata(array_wdata),
    .wipe_pin(wipe_pin), .debug_emulation_port_req(dbg_req),
    .fast_programming_port_req(fast_req),
    .debug_emulation_port_ok(dbg_ok), .fast_programming_port_ok(fast_ok),
    .bod_enable(bod_enable), .bod_reset_enable(bod_reset_enable),
    .boot_from_flash(boot_from_flash), .calib_bits(calib_bits), .irq(irq)
  );

  fbm_array_model flash (
    .clk(clk), .array_rd(array_rd), .array_word_addr(array_word_addr),
    .array_prog(array_prog), .array_wdata(array_wdata),
    .array_rdata(array_rdata), .prog_word(prog_word)
  );

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the under two thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data looked at in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask

  // keyed command, then the fixed run time plus margin
  task automatic cmd(input logic [3:0] op, input logic [9:0] arg);
    wr(`FBM_REG_CMD, {8'h5a, 6'h0, arg, 4'h0, op});
    repeat (`FBM_OP_CYC + 4) @(posedge clk);
  endtask

  task automatic dec(input logic [31:0] a, input fbm_sel_e e);
    @(posedge clk);
    bus_addr <= a;
    @(posedge clk);
    #1;
    chk("bus_sel", {30'h0, e}, {30'h0, bus_sel});
  endtask

  // hold the fetch until the hit pulse, bounded
  task automatic fetch(input logic [17:0] a, input logic [15:0] e);
    int i;
    @(posedge clk);
    fetch_addr <= a;
    fetch_req <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (fetch_hit === 1'b1) break;
    end
    chk("fetch_data", {16'h0, e}, {16'h0, fetch_data});
  endtask

  task automatic final_report();
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, fetch_req, wipe_pin, dbg_req, fast_req} = 0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    bus_addr = 32'h0;
    fetch_addr = 18'h0;
    failures = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(`FBM_REG_MODE, 32'h1);
    rd(`FBM_REG_STATUS, 32'h1);
    rd(`FBM_REG_LOCKS, 32'h0);
    chk("array_standby", 32'h1, {31'h0, array_standby});
    // fixed areas, rom at zero while gp bit 2 is clear
    dec(`FBM_FLASH_BASE + 32'h4, FBM_SEL_FLASH);
    dec(`FBM_SRAM_BASE + 32'h8, FBM_SEL_SRAM);
    dec(`FBM_ROM_BASE, FBM_SEL_ROM);
    dec(32'h0, FBM_SEL_ROM);
    dec(32'h0040_0000, FBM_SEL_NONE);
    // general purpose bits through set and clear commands
    cmd(4'h6, 10'h2);
    chk("boot_from_flash", 32'h1, {31'h0, boot_from_flash});
    dec(32'h0, FBM_SEL_FLASH);
    cmd(4'h6, 10'h0);
    cmd(4'h6, 10'h1);
    chk("bod_enable", 32'h1, {31'h0, bod_enable});
    cmd(4'h7, 10'h1);
    chk("bod_reset_enable", 32'h0, {31'h0, bod_reset_enable});
    rd(`FBM_REG_NVM, 32'h500);
    // unkeyed set is refused and flagged
    wr(`FBM_REG_CMD, 32'h0000_0206);
    repeat (`FBM_OP_CYC + 4) @(posedge clk);
    rd(`FBM_REG_STATUS, 32'h5);
    rd(`FBM_REG_NVM, 32'h500);
    // erase of a locked region aborts and interrupts
    wr(`FBM_REG_MODE, 32'h201);
    cmd(4'h4, 10'd64);
    rd(`FBM_REG_LOCKS, 32'h2);
    cmd(4'h2, 10'd64);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`FBM_REG_STATUS, 32'h3);
    rd(`FBM_REG_STATUS, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    cmd(4'h5, 10'd64);
    rd(`FBM_REG_LOCKS, 32'h0);
    cmd(4'h2, 10'd64);
    rd(`FBM_REG_STATUS, 32'h1);
    // buffer filled by two strobes with an idle cycle between, then a page program
    wr(`FBM_REG_WADDR, 32'h0);
    wr(`FBM_REG_WBUF, 32'hcafe_0001);
    wr(`FBM_REG_WBUF, 32'hcafe_0002);
    wr(`FBM_REG_CMD, 32'h5a00_0001);
    repeat (10) @(posedge clk);
    chk("array_prog", 32'h1, {31'h0, array_prog});
    chk("array_standby", 32'h0, {31'h0, array_standby});
    repeat (`FBM_OP_CYC) @(posedge clk);
    chk("prog_word", 32'hcafe_0002, prog_word);
    rd(`FBM_REG_STATUS, 32'h1);
    chk("array_standby", 32'h1, {31'h0, array_standby});
    // miss then sequential halfword from the prefetched word
    fetch(18'h00106, 16'hffbe);
    fetch(18'h00108, 16'h0042);
    @(posedge clk);
    fetch_req <= 1'b0;
    // security closes both outside ports
    dbg_req <= 1'b1;
    fast_req <= 1'b1;
    cmd(4'h4, 10'h0);
    cmd(4'h8, 10'h0);
    chk("dbg_ok", 32'h0, {31'h0, dbg_ok});
    chk("fast_ok", 32'h0, {31'h0, fast_ok});
    // wipe clears locks and gp bits, security waits for full erase
    wipe_pin <= 1'b1;
    repeat (25) @(posedge clk);
    wipe_pin <= 1'b0;
    rd(`FBM_REG_LOCKS, 32'h0);
    rd(`FBM_REG_NVM, 32'h0);
    chk("calib_bits", `FBM_CAL_RESET, {24'h0, calib_bits});
    rd(`FBM_REG_STATUS, 32'h11);
    cmd(4'h3, 10'h0);
    rd(`FBM_REG_STATUS, 32'h1);
    chk("fast_ok", 32'h1, {31'h0, fast_ok});
    chk("dbg_ok", 32'h1, {31'h0, dbg_ok});
    // remap adds the sram alias at zero
    dec(32'h0, FBM_SEL_ROM);
    wr(`FBM_REG_REMAP, 32'h1);
    dec(32'h0, FBM_SEL_SRAM);
    dec(`FBM_FLASH_BASE, FBM_SEL_FLASH);
    // three wait states, completion interrupt enabled
    wr(`FBM_REG_MODE, 32'h303);
    rd(`FBM_REG_MODE, 32'h303);
    chk("irq", 32'h1, {31'h0, irq});
    fetch(18'h0010c, 16'h0043);
    // a second reset drops the remap alias
    @(posedge clk);
    fetch_req <= 1'b0;
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    dec(32'h0, FBM_SEL_ROM);
    rd(`FBM_REG_MODE, 32'h1);
    final_report();
  end
endmodule
